// >>> timer16_pkg.sv
package timer16_pkg;

  // Register indices on the 8-bit CPU port.
  localparam int ADDR_W = 4;
  localparam logic [3:0] A_CTRL_A = 4'h0;
  localparam logic [3:0] A_CTRL_B = 4'h1;
  localparam logic [3:0] A_IRQ_MASK = 4'h2;
  localparam logic [3:0] A_IRQ_FLAGS = 4'h3;
  localparam logic [3:0] A_CNT_L = 4'h4;
  localparam logic [3:0] A_CNT_H = 4'h5;
  localparam logic [3:0] A_CAP_L = 4'h6;
  localparam logic [3:0] A_CAP_H = 4'h7;
  localparam logic [3:0] A_CMPA_L = 4'h8;
  localparam logic [3:0] A_CMPA_H = 4'h9;
  localparam logic [3:0] A_CMP_CTRL = 4'hA;

  // Field positions.
  localparam int B_NOISE_EN = 7;
  localparam int B_EDGE_RISE = 6;
  localparam int B_WGM_HI = 3;
  localparam int B_CS_LO = 0;
  localparam int B_WGM_LO = 0;
  localparam int B_CAP_FLAG = 5;
  localparam int B_OVF_FLAG = 0;
  localparam int B_CAP_SRC = 2;

  // Reset values.
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // Counter limits.
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // Clock source codes.
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_SYS = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Waveform mode codes.
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_FAST8 = 4'h5;
  localparam logic [3:0] WGM_FAST9 = 4'h6;
  localparam logic [3:0] WGM_FAST10 = 4'h7;
  localparam logic [3:0] WGM_PFC_ICR = 4'h8;
  localparam logic [3:0] WGM_PFC_A = 4'h9;
  localparam logic [3:0] WGM_PC_ICR = 4'hA;
  localparam logic [3:0] WGM_PC_A = 4'hB;
  localparam logic [3:0] WGM_CTC_ICR = 4'hC;
  localparam logic [3:0] WGM_FAST_ICR = 4'hE;
  localparam logic [3:0] WGM_FAST_A = 4'hF;

  // Noise filter depth.
  localparam int FILT_LEN = 4;
  localparam logic [3:0] FILT_ALL0 = 4'h0;
  localparam logic [3:0] FILT_ALL1 = 4'hF;

  typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} dir_e;

  function automatic logic icr_is_top(input logic [3:0] m);
    icr_is_top = (m == WGM_PFC_ICR) || (m == WGM_PC_ICR) || (m == WGM_CTC_ICR) ||
                 (m == WGM_FAST_ICR);
  endfunction

endpackage

// >>> noise_filter.sv
`timescale 1ns/1ps
module noise_filter (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Control.
  input wire logic enable,
  // Sample in and filtered level out.
  input wire logic din,
  output logic dout
);

  logic [3:0] hist_reg;
  logic dout_reg;
  wire agree = (hist_reg == timer16_pkg::FILT_ALL0) || (hist_reg == timer16_pkg::FILT_ALL1);
  wire dout_next = enable ? (agree ? hist_reg[timer16_pkg::FILT_LEN-1] : dout_reg) : din;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hist_reg <= timer16_pkg::FILT_ALL0;
      dout_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[2:0], din};
      dout_reg <= dout_next; // [RULE_18] [RULE_19]
    end
  end

  assign dout = dout_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_filter_holds: assert property ( // [RULE_18]
    enable && !agree |=> $stable(dout_reg))
    else $error("Filter output moved while samples disagreed.");

  chk_filter_bypass: assert property ( // [RULE_19]
    !enable |=> dout_reg == $past(din))
    else $error("Bypassed filter did not follow its input.");

endmodule

// >>> count_sequencer.sv
`timescale 1ns/1ps
module count_sequencer (
  // Present state.
  input wire logic [15:0] cnt,
  input wire timer16_pkg::dir_e dir,
  // Mode and top sources.
  input wire logic [3:0] wgm,
  input wire logic [15:0] cmp_a,
  input wire logic [15:0] cap_val,
  // Next state and indicators.
  output logic [15:0] cnt_next,
  output timer16_pkg::dir_e dir_next,
  output logic top_hit,
  output logic bottom_hit,
  output logic ovf_hit,
  output logic up_down
);

  logic [15:0] top_val;
  logic fast;

  always_comb begin
    case (wgm)
      timer16_pkg::WGM_PC8, timer16_pkg::WGM_FAST8: top_val = timer16_pkg::TOP_8BIT; // [RULE_24]
      timer16_pkg::WGM_PC9, timer16_pkg::WGM_FAST9: top_val = timer16_pkg::TOP_9BIT;
      timer16_pkg::WGM_PC10, timer16_pkg::WGM_FAST10: top_val = timer16_pkg::TOP_10BIT;
      timer16_pkg::WGM_CTC_A, timer16_pkg::WGM_PFC_A, timer16_pkg::WGM_PC_A,
      timer16_pkg::WGM_FAST_A: top_val = cmp_a;
      timer16_pkg::WGM_PFC_ICR, timer16_pkg::WGM_PC_ICR, timer16_pkg::WGM_CTC_ICR,
      timer16_pkg::WGM_FAST_ICR: top_val = cap_val;
      default: top_val = timer16_pkg::CNT_MAX;
    endcase
  end

  assign up_down = (wgm >= timer16_pkg::WGM_PC8 && wgm <= timer16_pkg::WGM_PC10) ||
                   (wgm >= timer16_pkg::WGM_PFC_ICR && wgm <= timer16_pkg::WGM_PC_A);
  assign fast = (wgm >= timer16_pkg::WGM_FAST8 && wgm <= timer16_pkg::WGM_FAST10) ||
                (wgm >= timer16_pkg::WGM_FAST_ICR);
  assign top_hit = (cnt == top_val); // [RULE_10]
  assign bottom_hit = (cnt == timer16_pkg::CNT_BOTTOM); // [RULE_10]

  // Next count for one timer tick, chosen by the mode.
  always_comb begin
    dir_next = dir;
    cnt_next = cnt + timer16_pkg::CNT_ONE;
    if (up_down) begin
      if (dir == timer16_pkg::DIR_UP && top_hit) begin
        dir_next = timer16_pkg::DIR_DOWN;
        cnt_next = cnt - timer16_pkg::CNT_ONE;
      end else if (dir == timer16_pkg::DIR_DOWN && !bottom_hit) begin
        cnt_next = cnt - timer16_pkg::CNT_ONE; // [RULE_05]
      end else if (dir == timer16_pkg::DIR_DOWN) begin
        dir_next = timer16_pkg::DIR_UP;
      end
    end else if (top_hit) begin
      cnt_next = timer16_pkg::CNT_BOTTOM; // [RULE_05] [RULE_08]
    end
  end

  assign ovf_hit = up_down ? bottom_hit :
                   (fast ? top_hit : (cnt == timer16_pkg::CNT_MAX)); // [RULE_09]

endmodule

// >>> timer16_counter_input_capture.sv
// Operation
// RULE_01 - Counter appears as low and high byte; high byte access uses holding register.
// RULE_02 - Low byte read fills holding register; low byte write loads high byte.
// RULE_03 - Holding register keeps its value between accesses for reuse.
// RULE_04 - Three-bit clock select picks tick source; zero stops the counter.
// RULE_05 - Each timer tick clears, increments or decrements the counter per mode.
// RULE_06 - Counter is readable and writable whether or not ticks arrive.
// RULE_07 - A CPU counter write beats a clear or count in the same cycle.
// RULE_08 - Four-bit waveform mode, split over control A and B, sets count sequence.
// RULE_09 - Overflow flag sets where the mode defines and can request an interrupt.
// RULE_10 - Bottom indicator at zero, top indicator at the sequence's highest value.
// RULE_11 - Accepted edge on the selected source copies the counter into capture register.
// RULE_12 - Capture flag sets with the copy; requests interrupt when enabled.
// RULE_13 - Capture flag clears on interrupt acknowledge or writing one to it.
// RULE_14 - Capture low byte read fills holding register; high read returns it.
// RULE_15 - Capture register writable only in modes using it as top.
// RULE_16 - Source select bit switches capture trigger from pin to comparator output.
// RULE_17 - Switching source may capture; software clears the flag afterwards.
// RULE_18 - Enabled filter changes output only when four samples agree.
// RULE_19 - Filter enable bit inserts the filter, adding four system cycles latency.
// RULE_20 - Filter and edge detector stay active except in capture-as-top modes.
// RULE_21 - Driving the capture pin from its port logic can trigger a capture.
// RULE_22 - Every new capture overwrites the capture register, read or not.
// RULE_23 - Low byte write loads holding byte and written byte in one cycle.
// RULE_24 - Top is 0x00FF, 0x01FF, 0x03FF, compare register A or capture register.
// RULE_25 - Edge select bit chooses rising or falling capture edge.
// RULE_26 - Capture pin and comparator output are synchronised before the filter.
`timescale 1ns/1ps
module timer16_counter_input_capture (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // CPU register port.
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // Tick sources: divided enables for 8, 64, 256 and 1024, and the count pin.
  input wire logic [3:0] prescale_ticks,
  input wire logic external_count_pin,
  // Capture sources.
  input wire logic capture_pin,
  input wire logic comparator_output,
  // Interrupt requests and acknowledges.
  input wire logic capture_irq_ack,
  input wire logic overflow_irq_ack,
  output logic capture_irq,
  output logic overflow_irq,
  // Counter indicators.
  output logic timer_tick,
  output logic count_at_top,
  output logic count_at_bottom
);

  // Registers.
  logic [15:0] count_reg;
  logic [15:0] capture_reg;
  logic [15:0] cmp_a_reg;
  logic [7:0] hold_reg;
  logic [7:0] rdata_reg;
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic cap_ie_reg;
  logic ovf_ie_reg;
  logic cap_flag_reg;
  logic ovf_flag_reg;
  logic cap_src_reg;
  timer16_pkg::dir_e dir_reg;

  // Synchronisers and edge state.
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic cmp_meta_reg;
  logic cmp_sync_reg;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic filt_prev_reg;

  // Sequencer and filter outputs.
  logic [15:0] seq_cnt;
  timer16_pkg::dir_e seq_dir;
  logic top_hit;
  logic bottom_hit;
  logic ovf_hit;
  logic up_down;
  logic filt_out;

  // Decoded controls.
  wire [2:0] clk_sel = ctrl_b_reg[timer16_pkg::B_CS_LO +: 3];
  wire [3:0] wgm = {ctrl_b_reg[timer16_pkg::B_WGM_HI +: 2],
                    ctrl_a_reg[timer16_pkg::B_WGM_LO +: 2]}; // [RULE_08]
  wire noise_en = ctrl_b_reg[timer16_pkg::B_NOISE_EN];
  wire edge_rise = ctrl_b_reg[timer16_pkg::B_EDGE_RISE];
  wire icr_top = timer16_pkg::icr_is_top(wgm);

  // Address decode.
  wire wr_ctrl_a = cpu_wr && (cpu_addr == timer16_pkg::A_CTRL_A);
  wire wr_ctrl_b = cpu_wr && (cpu_addr == timer16_pkg::A_CTRL_B);
  wire wr_mask = cpu_wr && (cpu_addr == timer16_pkg::A_IRQ_MASK);
  wire wr_flags = cpu_wr && (cpu_addr == timer16_pkg::A_IRQ_FLAGS);
  wire wr_cnt_l = cpu_wr && (cpu_addr == timer16_pkg::A_CNT_L);
  wire wr_cap_l = cpu_wr && (cpu_addr == timer16_pkg::A_CAP_L) && icr_top; // [RULE_15]
  wire wr_cmpa_l = cpu_wr && (cpu_addr == timer16_pkg::A_CMPA_L);
  wire wr_cmp_ctrl = cpu_wr && (cpu_addr == timer16_pkg::A_CMP_CTRL);
  wire wr_high = cpu_wr && ((cpu_addr == timer16_pkg::A_CNT_H) ||
                 (cpu_addr == timer16_pkg::A_CAP_H) || (cpu_addr == timer16_pkg::A_CMPA_H));
  wire rd_cnt_l = cpu_rd && (cpu_addr == timer16_pkg::A_CNT_L);
  wire rd_cap_l = cpu_rd && (cpu_addr == timer16_pkg::A_CAP_L);

  // Tick selection.
  wire ext_fall = ext_prev_reg && !ext_sync_reg;
  wire ext_rise = !ext_prev_reg && ext_sync_reg;
  wire tick_sel = (clk_sel == timer16_pkg::CS_SYS) ? 1'b1 :
                  (clk_sel == timer16_pkg::CS_DIV8) ? prescale_ticks[0] :
                  (clk_sel == timer16_pkg::CS_DIV64) ? prescale_ticks[1] :
                  (clk_sel == timer16_pkg::CS_DIV256) ? prescale_ticks[2] :
                  (clk_sel == timer16_pkg::CS_DIV1024) ? prescale_ticks[3] :
                  (clk_sel == timer16_pkg::CS_EXT_FALL) ? ext_fall :
                  (clk_sel == timer16_pkg::CS_EXT_RISE) ? ext_rise : 1'b0; // [RULE_04]

  // Capture source, filter and edge detection.
  wire cap_src_level = cap_src_reg ? cmp_sync_reg : pin_sync_reg; // [RULE_16] [RULE_17]
  wire edge_seen = edge_rise ? (filt_out && !filt_prev_reg) :
                   (!filt_out && filt_prev_reg); // [RULE_25]
  wire cap_evt = edge_seen && !icr_top; // [RULE_20]

  // Next values.
  wire [15:0] count_next = wr_cnt_l ? {hold_reg, cpu_wdata} :
                           (tick_sel ? seq_cnt : count_reg); // [RULE_07] [RULE_23]
  wire [15:0] capture_next = cap_evt ? count_reg :
                             (wr_cap_l ? {hold_reg, cpu_wdata} : capture_reg); // [RULE_22]
  wire [7:0] hold_next = wr_high ? cpu_wdata :
                         (rd_cnt_l ? count_reg[15:8] :
                         (rd_cap_l ? capture_reg[15:8] : hold_reg)); // [RULE_02] [RULE_14]
  wire cap_clear = (wr_flags && cpu_wdata[timer16_pkg::B_CAP_FLAG]) || capture_irq_ack;
  wire ovf_clear = (wr_flags && cpu_wdata[timer16_pkg::B_OVF_FLAG]) || overflow_irq_ack;
  wire ovf_set = tick_sel && !wr_cnt_l && ovf_hit;
  wire cap_flag_next = cap_evt || (cap_flag_reg && !cap_clear); // [RULE_12] [RULE_13]
  wire ovf_flag_next = ovf_set || (ovf_flag_reg && !ovf_clear); // [RULE_09]

  // Read mux; counter and capture high byte locations return the holding register.
  wire [7:0] flags_rd = {2'b00, cap_flag_reg, 4'h0, ovf_flag_reg};
  wire [7:0] mask_rd = {2'b00, cap_ie_reg, 4'h0, ovf_ie_reg};
  wire [7:0] rdata_next =
    (cpu_addr == timer16_pkg::A_CTRL_A) ? ctrl_a_reg :
    (cpu_addr == timer16_pkg::A_CTRL_B) ? ctrl_b_reg :
    (cpu_addr == timer16_pkg::A_IRQ_MASK) ? mask_rd :
    (cpu_addr == timer16_pkg::A_IRQ_FLAGS) ? flags_rd :
    (cpu_addr == timer16_pkg::A_CNT_L) ? count_reg[7:0] : // [RULE_06]
    (cpu_addr == timer16_pkg::A_CAP_L) ? capture_reg[7:0] :
    (cpu_addr == timer16_pkg::A_CMPA_L) ? cmp_a_reg[7:0] :
    (cpu_addr == timer16_pkg::A_CMPA_H) ? cmp_a_reg[15:8] :
    (cpu_addr == timer16_pkg::A_CNT_H) ? hold_reg : // [RULE_01]
    (cpu_addr == timer16_pkg::A_CAP_H) ? hold_reg : // [RULE_14]
    (cpu_addr == timer16_pkg::A_CMP_CTRL) ? {5'h00, cap_src_reg, 2'h0} :
    timer16_pkg::BYTE_ZERO;

  count_sequencer u_seq (
    .cnt(count_reg),
    .dir(dir_reg),
    .wgm(wgm),
    .cmp_a(cmp_a_reg),
    .cap_val(capture_reg),
    .cnt_next(seq_cnt),
    .dir_next(seq_dir),
    .top_hit(top_hit),
    .bottom_hit(bottom_hit),
    .ovf_hit(ovf_hit),
    .up_down(up_down)
  );

  noise_filter u_filt (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(noise_en),
    .din(cap_src_level),
    .dout(filt_out)
  );

  // Input synchronisers; the pin level includes any drive from its own port logic.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      filt_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= capture_pin; // [RULE_26] [RULE_21]
      pin_sync_reg <= pin_meta_reg;
      cmp_meta_reg <= comparator_output; // [RULE_26]
      cmp_sync_reg <= cmp_meta_reg;
      ext_meta_reg <= external_count_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      filt_prev_reg <= filt_out;
    end
  end

  // Counter, capture and holding registers.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_reg <= timer16_pkg::WORD_ZERO;
      dir_reg <= timer16_pkg::DIR_UP;
      capture_reg <= timer16_pkg::WORD_ZERO;
      hold_reg <= timer16_pkg::BYTE_ZERO;
    end else begin
      count_reg <= count_next; // [RULE_05]
      if (tick_sel && !wr_cnt_l) begin
        dir_reg <= up_down ? seq_dir : timer16_pkg::DIR_UP;
      end
      capture_reg <= capture_next; // [RULE_11]
      hold_reg <= hold_next; // [RULE_03]
    end
  end

  // Control, compare, mask, flag and read data registers.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_a_reg <= timer16_pkg::BYTE_ZERO;
      ctrl_b_reg <= timer16_pkg::BYTE_ZERO;
      cmp_a_reg <= timer16_pkg::WORD_ZERO;
      cap_ie_reg <= 1'b0;
      ovf_ie_reg <= 1'b0;
      cap_src_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      rdata_reg <= timer16_pkg::BYTE_ZERO;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_reg <= cpu_wdata;
      end
      if (wr_ctrl_b) begin
        ctrl_b_reg <= cpu_wdata;
      end
      if (wr_cmpa_l) begin
        cmp_a_reg <= {hold_reg, cpu_wdata};
      end
      if (wr_mask) begin
        cap_ie_reg <= cpu_wdata[timer16_pkg::B_CAP_FLAG];
        ovf_ie_reg <= cpu_wdata[timer16_pkg::B_OVF_FLAG];
      end
      if (wr_cmp_ctrl) begin
        cap_src_reg <= cpu_wdata[timer16_pkg::B_CAP_SRC];
      end
      cap_flag_reg <= cap_flag_next;
      ovf_flag_reg <= ovf_flag_next;
      if (cpu_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign cpu_rdata = rdata_reg;
  assign capture_irq = cap_flag_reg && cap_ie_reg; // [RULE_12]
  assign overflow_irq = ovf_flag_reg && ovf_ie_reg; // [RULE_09]
  assign timer_tick = tick_sel;
  assign count_at_top = top_hit;
  assign count_at_bottom = bottom_hit;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_high_write;
    cpu_wr && (cpu_addr == timer16_pkg::A_CNT_H);
  endsequence

  sequence s_low_write;
    cpu_wr && (cpu_addr == timer16_pkg::A_CNT_L);
  endsequence

  sequence s_bus_idle;
    !cpu_wr && !cpu_rd;
  endsequence

  chk_count_pair_write: assert property ( // [RULE_23]
    s_high_write ##1 s_bus_idle ##1 (s_low_write and !rd_cnt_l) |=>
    count_reg == {$past(cpu_wdata, 3), $past(cpu_wdata)})
    else $error("High then low write did not load the counter.");

  chk_cnt_write_wins: assert property ( // [RULE_07]
    s_low_write and tick_sel |=> count_reg == {$past(hold_reg), $past(cpu_wdata)})
    else $error("Counter write lost against a tick.");

  chk_stopped_holds: assert property ( // [RULE_04]
    clk_sel == timer16_pkg::CS_STOP && !wr_cnt_l |=> $stable(count_reg))
    else $error("Counter moved with no clock selected.");

  chk_low_read_hold: assert property ( // [RULE_02]
    rd_cnt_l && !wr_high |=> hold_reg == $past(count_reg[15:8]) &&
                             cpu_rdata == $past(count_reg[7:0]))
    else $error("Low byte read did not fill the holding register.");

  chk_hold_kept: assert property ( // [RULE_03]
    s_bus_idle [*2] |=> $stable(hold_reg))
    else $error("Holding register changed without access.");

  chk_capture_copy: assert property ( // [RULE_11]
    cap_evt |=> capture_reg == $past(count_reg) && cap_flag_reg)
    else $error("Capture did not copy the counter and set the flag.");

  chk_flag_clear: assert property ( // [RULE_13]
    cap_flag_reg && capture_irq_ack && !cap_evt |=> !cap_flag_reg)
    else $error("Capture flag survived its acknowledge.");

  chk_capture_locked: assert property ( // [RULE_15]
    cpu_wr && cpu_addr == timer16_pkg::A_CAP_L && !icr_top |=> $stable(capture_reg) || $past(cap_evt))
    else $error("Capture register written outside a capture-top mode.");

  chk_ctc_clear: assert property ( // [RULE_05]
    tick_sel && !wr_cnt_l && top_hit && !up_down |=> count_reg == timer16_pkg::CNT_BOTTOM)
    else $error("Counter did not clear at top.");

  chk_ovf_set: assert property ( // [RULE_09]
    ovf_set |=> ovf_flag_reg [*2] or (ovf_flag_reg ##1 !ovf_flag_reg))
    else $error("Overflow flag not set at the mode's overflow point.");

  chk_high_read_temp: assert property ( // [RULE_01]
    cpu_rd && (cpu_addr == timer16_pkg::A_CNT_H || cpu_addr == timer16_pkg::A_CAP_H) |=>
    cpu_rdata == $past(hold_reg))
    else $error("High byte read did not return the holding register.");

  chk_cap_low_read: assert property ( // [RULE_14]
    rd_cap_l && !wr_high |=> hold_reg == $past(capture_reg[15:8]))
    else $error("Capture low read did not fill the holding register.");

  chk_ovf_ack_clear: assert property ( // [RULE_09]
    ovf_flag_reg && overflow_irq_ack && !ovf_set |=> !ovf_flag_reg)
    else $error("Overflow flag survived its acknowledge.");

  chk_flag_write_one: assert property ( // [RULE_13]
    cap_flag_reg && wr_flags && cpu_wdata[timer16_pkg::B_CAP_FLAG] && !cap_evt |=>
    !cap_flag_reg)
    else $error("Writing one did not clear the capture flag.");

  chk_ext_rise_tick: assert property ( // [RULE_04]
    clk_sel == timer16_pkg::CS_EXT_RISE && wgm == timer16_pkg::WGM_NORMAL && !wr_cnt_l &&
    $rose(ext_sync_reg) |=> count_reg == $past(count_reg) + timer16_pkg::CNT_ONE)
    else $error("Rising count pin edge did not advance the counter.");

endmodule

// >>> cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
  // Clock.
  input wire logic core_clk,
  // Register port.
  output logic [3:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata
);
  initial begin
    cpu_addr = 4'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end
  // The request is held across the taking edge and released after it.
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge core_clk);
    cpu_wr = 1'b0;
    cpu_wdata = ~d;
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge core_clk);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask
  // High byte goes first on a write.
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr8(a + 4'h1, v[15:8]);
    wr8(a, v[7:0]);
  endtask
  // Low byte goes first on a read.
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 4'h1, v[15:8]);
  endtask
endmodule

// >>> tb_timer16_counter_input_capture.sv
`timescale 1ns/1ps
module tb_timer16_counter_input_capture;
  logic core_clk;
  logic resetn;
  logic [3:0] cpu_addr;
  logic cpu_wr;
  logic cpu_rd;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic capture_pin;
  logic comparator_output;
  logic cap_ack;
  logic ovf_ack;
  logic capture_irq;
  logic overflow_irq;
  logic timer_tick;
  logic count_at_top;
  logic count_at_bottom;
  logic [3:0] pre_tick;
  logic ext_pin;
  logic [15:0] v;
  logic [7:0] b;
  logic [15:0] top;
  int n_fail;
  int checked;

  timer16_counter_input_capture dut (
    .core_clk(core_clk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .prescale_ticks(pre_tick), .external_count_pin(ext_pin), .capture_pin(capture_pin),
    .comparator_output(comparator_output), .capture_irq_ack(cap_ack),
    .overflow_irq_ack(ovf_ack), .capture_irq(capture_irq), .overflow_irq(overflow_irq),
    .timer_tick(timer_tick), .count_at_top(count_at_top), .count_at_bottom(count_at_bottom)
  );
  cpu_model cpu (
    .core_clk(core_clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pin(input logic lv);
    @(negedge core_clk);
    capture_pin = lv;
  endtask
  task automatic close_out();
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    close_out();
  end

  initial begin
    n_fail = 0;
    checked = 0;
    resetn = 1'b0;
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    cap_ack = 1'b0;
    ovf_ack = 1'b0;
    pre_tick = 4'h0;
    ext_pin = 1'b0;
    cyc(3);
    resetn = 1'b1;
    cpu.rd16(timer16_pkg::A_CNT_L, v);
    chk("count reset", 16'h0000, v);
    chk("bottom", 16'h0001, 16'(count_at_bottom));
    cpu.wr16(timer16_pkg::A_CNT_L, 16'h1234);
    cyc(10);
    cpu.rd16(timer16_pkg::A_CNT_L, v);
    chk("count stopped", 16'h1234, v);
    cpu.wr16(timer16_pkg::A_CMPA_L, 16'hAB01);
    cpu.wr8(timer16_pkg::A_CNT_L, 8'h02);
    cpu.rd16(timer16_pkg::A_CNT_L, v);
    chk("holding reuse", 16'hAB02, v);
    cpu.wr8(timer16_pkg::A_CTRL_B, {5'h00, timer16_pkg::CS_SYS});
    cpu.wr16(timer16_pkg::A_CNT_L, 16'h0010);
    cpu.rd8(timer16_pkg::A_CNT_L, b);
    chk("write beats tick", 16'h0011, {8'h00, b});
    chk("tick", 16'h0001, 16'(timer_tick));
    cpu.wr8(timer16_pkg::A_IRQ_MASK, 8'h21);
    cpu.wr16(timer16_pkg::A_CNT_L, 16'hFFF0);
    cyc(30);
    cpu.wr8(timer16_pkg::A_CTRL_B, 8'h00);
    chk("overflow irq", 16'h0001, 16'(overflow_irq));
    @(negedge core_clk) ovf_ack = 1'b1;
    @(negedge core_clk) ovf_ack = 1'b0;
    cpu.rd8(timer16_pkg::A_IRQ_FLAGS, b);
    chk("flags clear", 16'h0000, {8'h00, b});
    cpu.wr16(timer16_pkg::A_CNT_L, 16'h0100);
    cpu.wr8(timer16_pkg::A_CTRL_B, 8'h40);
    pin(1'b1);
    cyc(6);
    chk("capture irq", 16'h0001, 16'(capture_irq));
    cpu.wr16(timer16_pkg::A_CNT_L, 16'h0200);
    pin(1'b0);
    cyc(6);
    cpu.rd16(timer16_pkg::A_CAP_L, v);
    chk("rise only", 16'h0100, v);
    cpu.wr8(timer16_pkg::A_CTRL_B, 8'h00);
    pin(1'b1);
    cyc(2);
    pin(1'b0);
    cyc(6);
    cpu.rd16(timer16_pkg::A_CAP_L, v);
    chk("overwrite", 16'h0200, v);
    @(negedge core_clk) cap_ack = 1'b1;
    @(negedge core_clk) cap_ack = 1'b0;
    chk("ack clears", 16'h0000, 16'(capture_irq));
    cpu.wr8(timer16_pkg::A_CTRL_B, 8'hC0);
    pin(1'b1);
    cyc(1);
    pin(1'b0);
    cyc(10);
    chk("glitch", 16'h0000, 16'(capture_irq));
    pin(1'b1);
    cyc(5);
    chk("filter delay", 16'h0000, 16'(capture_irq));
    cyc(5);
    chk("filter capture", 16'h0001, 16'(capture_irq));
    cpu.wr8(timer16_pkg::A_CTRL_B, 8'h40);
    cpu.wr8(timer16_pkg::A_CMP_CTRL, 8'h04);
    cpu.wr8(timer16_pkg::A_IRQ_FLAGS, 8'h20);
    chk("write one clears", 16'h0000, 16'(capture_irq));
    pin(1'b0);
    cyc(2);
    pin(1'b1);
    cyc(6);
    chk("pin ignored", 16'h0000, 16'(capture_irq));
    @(negedge core_clk) comparator_output = 1'b1;
    cyc(6);
    chk("comparator capture", 16'h0001, 16'(capture_irq));
    cpu.wr8(timer16_pkg::A_CMP_CTRL, 8'h00);
    cpu.wr8(timer16_pkg::A_IRQ_FLAGS, 8'h20);
    cpu.wr16(timer16_pkg::A_CAP_L, 16'h7755);
    cpu.rd16(timer16_pkg::A_CAP_L, v);
    chk("capture locked", 16'h0200, v);
    cpu.wr8(timer16_pkg::A_CTRL_B, 8'h58);
    cpu.wr16(timer16_pkg::A_CAP_L, 16'h0321);
    pin(1'b0);
    cyc(2);
    pin(1'b1);
    cyc(6);
    chk("no capture as top", 16'h0000, 16'(capture_irq));
    cpu.rd16(timer16_pkg::A_CAP_L, v);
    chk("capture written", 16'h0321, v);
    cpu.wr8(timer16_pkg::A_CTRL_B, 8'h08);
    for (int i = 0; i < 3; i++) begin
      top = (16'h0100 << i) - 16'h0001;
      cpu.wr8(timer16_pkg::A_CTRL_A, 8'(i + 1));
      cpu.wr16(timer16_pkg::A_CNT_L, top - 16'h0001);
      chk("below top", 16'h0000, 16'(count_at_top));
      cpu.wr16(timer16_pkg::A_CNT_L, top);
      chk("fixed top", 16'h0001, 16'(count_at_top));
    end
    cpu.wr8(timer16_pkg::A_CTRL_A, 8'h00);
    cpu.wr16(timer16_pkg::A_CNT_L, 16'hAB01);
    chk("compare top", 16'h0001, 16'(count_at_top));
    cpu.wr16(timer16_pkg::A_CNT_L, 16'h0000);
    cpu.wr8(timer16_pkg::A_CTRL_B, {5'h00, timer16_pkg::CS_EXT_RISE});
    for (int i = 0; i < 3; i++) begin
      ext_pin = 1'b1;
      cyc(4);
      ext_pin = 1'b0;
      cyc(4);
    end
    cpu.rd16(timer16_pkg::A_CNT_L, v);
    chk("external edges", 16'h0003, v);
    cpu.wr8(timer16_pkg::A_CTRL_B, {5'h00, timer16_pkg::CS_DIV8});
    pre_tick = 4'hE;
    cyc(1);
    pre_tick = 4'h1;
    cyc(1);
    pre_tick = 4'h0;
    cpu.rd16(timer16_pkg::A_CNT_L, v);
    chk("prescale tap", 16'h0004, v);
    close_out();
  end
endmodule
